// ===== rtl/etp_defs.svh
`ifndef ETP_DEFS_SVH
`define ETP_DEFS_SVH
// Supply monitor filter and hysteresis
`define ETP_SUPPLY_FILT_CYC 16'h0100
`define ETP_SUPPLY_CNT_W 16
// High-pass corner shift (alpha = 2^-k)
`define ETP_HPF_SHIFT 10
// Low-pass corner: 8 Hz at the sample rate
`define ETP_LPF_CORNER_MHZ 8000
`define ETP_SAMPLE_RATE_HZ 40000
// Pole factor 2*pi*fc/fs, scaled by 2^16
`define ETP_LPF_COEF (((6283 * `ETP_LPF_CORNER_MHZ) / `ETP_SAMPLE_RATE_HZ) * 65 / 1000)
`define ETP_LPF_COEF_SHIFT 16
// Slow outputs are 160 times slower than calibration output
`define ETP_SLOW_RATIO 160
`define ETP_PULSE_LEN_CYC 8'h08
`endif

// ===== rtl/etp_pkg.sv
package etp_pkg;
	typedef enum logic [1:0] {
		ETP_SUP_LOW,
		ETP_SUP_RISE,
		ETP_SUP_GOOD,
		ETP_SUP_FALL
	} etp_sup_t;
endpackage : etp_pkg

// ===== rtl/etp_top.sv
`timescale 1ns/1ps
`include "etp_defs.svh"
// How it works
// RL1 - Every pulse output is held low while the supply is not reported good.
// RL2 - The supply-good input must hold its new level for a filter period before it is accepted.
// RL3 - Each current sample has its dc offset removed by a high-pass filter before multiplying.
// RL4 - Voltage samples get the same high-pass filter so both channels share its phase shift.
// RL5 - Each phase product passes a first-order low-pass filter with an 8 Hz corner.
// RL6 - The filtered total is accumulated and a pulse is issued each time it crosses a threshold while no pulse of that output is running.
// RL7 - The calibration accumulator threshold is 160 times smaller than the slow one.
// RL8 - With sum mode high the phase powers add with sign, with it low their magnitudes add.
// RL9 - In magnitude mode each phase contributes a positive value whatever its sign.
// RL10 - The reverse-power flag rises whenever any phase power is negative while the supply is good, in either mode.
// RL11 - A counter on the calibration output should average its rate over time.
// RL12 - The reader treats pulses as asynchronous and allows one pulse of count error.
// RL13 - The slow energy outputs give each event as an active-high pulse.
// RL14 - All logic runs on sys_clk and every output is a flip-flop.
module etp_top #(
	parameter int DW        = 16,
	parameter int AW        = 40,
	parameter int SLOW_THR  = 32'h0400_0000
) (
	input  wire logic          sys_clk,
	input  wire logic          srst,
	input  wire logic          sample_valid,
	input  wire logic [DW-1:0] volt_a,
	input  wire logic [DW-1:0] volt_b,
	input  wire logic [DW-1:0] volt_c,
	input  wire logic [DW-1:0] curr_a,
	input  wire logic [DW-1:0] curr_b,
	input  wire logic [DW-1:0] curr_c,
	input  wire logic          supply_ok,
	input  wire logic          sum_mode_select,
	output logic               energy_pulse_a,
	output logic               energy_pulse_b,
	output logic               calib_pulse_out,
	output logic               reverse_power
);
	localparam int PW = 2 * DW;
	localparam int CAL_THR = SLOW_THR / `ETP_SLOW_RATIO;

	// Supply monitor
	etp_pkg::etp_sup_t sup_q;
	logic [`ETP_SUPPLY_CNT_W-1:0] sup_cnt_q;
	wire sup_good = (sup_q == etp_pkg::ETP_SUP_GOOD) || (sup_q == etp_pkg::ETP_SUP_FALL);
	wire sup_done = (sup_cnt_q == `ETP_SUPPLY_FILT_CYC);

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sup_q     <= etp_pkg::ETP_SUP_LOW;
			sup_cnt_q <= '0;
		end else begin
			unique case (sup_q)
				etp_pkg::ETP_SUP_LOW: begin
					sup_cnt_q <= '0;
					if (supply_ok) sup_q <= etp_pkg::ETP_SUP_RISE;
				end
				etp_pkg::ETP_SUP_RISE: begin // see RL2
					sup_cnt_q <= sup_cnt_q + 1'b1;
					if (!supply_ok) sup_q <= etp_pkg::ETP_SUP_LOW;
					else if (sup_done) sup_q <= etp_pkg::ETP_SUP_GOOD;
				end
				etp_pkg::ETP_SUP_GOOD: begin
					sup_cnt_q <= '0;
					if (!supply_ok) sup_q <= etp_pkg::ETP_SUP_FALL;
				end
				etp_pkg::ETP_SUP_FALL: begin // see RL2
					sup_cnt_q <= sup_cnt_q + 1'b1;
					if (supply_ok) sup_q <= etp_pkg::ETP_SUP_GOOD;
					else if (sup_done) sup_q <= etp_pkg::ETP_SUP_LOW;
				end
			endcase
		end
	end

	// Per-phase filter chain
	logic signed [DW-1:0] v_in [3];
	logic signed [DW-1:0] i_in [3];
	assign v_in[0] = volt_a;
	assign v_in[1] = volt_b;
	assign v_in[2] = volt_c;
	assign i_in[0] = curr_a;
	assign i_in[1] = curr_b;
	assign i_in[2] = curr_c;

	logic signed [PW-1:0] lpf_q [3];
	logic signed [PW-1:0] mag [3];
	logic [2:0] neg;

	for (genvar p = 0; p < 3; p++) begin : g_ph
		logic signed [DW+`ETP_HPF_SHIFT-1:0] iav_q;
		logic signed [DW+`ETP_HPF_SHIFT-1:0] vav_q;
		logic signed [DW-1:0] ihp_q;
		logic signed [DW-1:0] vhp_q;
		wire signed [DW+`ETP_HPF_SHIFT-1:0] iav_d =
			iav_q + DW'(i_in[p]) - (iav_q >>> `ETP_HPF_SHIFT);
		wire signed [DW+`ETP_HPF_SHIFT-1:0] vav_d =
			vav_q + DW'(v_in[p]) - (vav_q >>> `ETP_HPF_SHIFT);
		wire signed [PW-1:0] prod = ihp_q * vhp_q;
		wire signed [PW+`ETP_LPF_COEF_SHIFT-1:0] lpf_err =
			((PW + `ETP_LPF_COEF_SHIFT)'(prod) - (PW + `ETP_LPF_COEF_SHIFT)'(lpf_q[p]))
			* `ETP_LPF_COEF;
		always_ff @(posedge sys_clk) begin
			if (srst) begin
				iav_q    <= '0;
				vav_q    <= '0;
				ihp_q    <= '0;
				vhp_q    <= '0;
				lpf_q[p] <= '0;
			end else if (sample_valid) begin
				iav_q    <= iav_d;
				vav_q    <= vav_d;
				ihp_q    <= i_in[p] - DW'(iav_q >>> `ETP_HPF_SHIFT); // see RL3
				vhp_q    <= v_in[p] - DW'(vav_q >>> `ETP_HPF_SHIFT); // see RL4
				lpf_q[p] <= lpf_q[p] + PW'(lpf_err >>> `ETP_LPF_COEF_SHIFT); // see RL5
			end
		end
		assign neg[p] = lpf_q[p][PW-1];
		assign mag[p] = neg[p] ? -lpf_q[p] : lpf_q[p]; // see RL9
		a_mag_pos: assert property (@(posedge sys_clk) // see RL9
			(lpf_q[p] != {1'b1, {(PW-1){1'b0}}}) |-> !mag[p][PW-1])
			else $error("phase magnitude negative");
		a_hpf_hold: assert property (@(posedge sys_clk) disable iff (srst) // see RL3
			!sample_valid |=> $stable(ihp_q) && $stable(vhp_q))
			else $error("high-pass output moved without a sample");
		a_lpf_hold: assert property (@(posedge sys_clk) disable iff (srst) // see RL5
			!sample_valid |=> $stable(lpf_q[p]))
			else $error("low-pass output moved without a sample");
		a_lpf_step: assert property (@(posedge sys_clk) disable iff (srst) // see RL5
			(sample_valid && prod > lpf_q[p]) |=> lpf_q[p] >= $past(lpf_q[p]))
			else $error("low-pass moved away from its input");
	end

	// Sum of the three phases
	wire signed [PW+1:0] sum_signed = (PW+2)'(lpf_q[0]) + (PW+2)'(lpf_q[1]) + (PW+2)'(lpf_q[2]);
	wire signed [PW+1:0] sum_abs = (PW+2)'(mag[0]) + (PW+2)'(mag[1]) + (PW+2)'(mag[2]);
	wire signed [PW+1:0] total = sum_mode_select ? sum_signed : sum_abs; // see RL8
	wire [PW+1:0] total_mag = total[PW+1] ? -total : total;

	// Digital-to-frequency accumulators
	logic [AW-1:0] slow_acc_q;
	logic [AW-1:0] cal_acc_q;
	logic [7:0] slow_len_q;
	logic [7:0] cal_len_q;
	logic phase_q;
	wire [AW-1:0] slow_sum = slow_acc_q + AW'(total_mag);
	wire [AW-1:0] cal_sum = cal_acc_q + AW'(total_mag);
	wire slow_hit = sample_valid && (slow_sum >= AW'(SLOW_THR)); // see RL6
	wire cal_hit = sample_valid && (cal_sum >= AW'(CAL_THR)); // see RL7

	always_ff @(posedge sys_clk) begin
		if (srst || !sup_good) begin // see RL1
			slow_acc_q      <= '0;
			cal_acc_q       <= '0;
			slow_len_q      <= '0;
			cal_len_q       <= '0;
			phase_q         <= 1'b0;
			energy_pulse_a  <= 1'b0;
			energy_pulse_b  <= 1'b0;
			calib_pulse_out <= 1'b0;
			reverse_power   <= 1'b0;
		end else begin
			if (sample_valid) begin
				slow_acc_q <= slow_hit ? slow_sum - AW'(SLOW_THR) : slow_sum;
				cal_acc_q  <= cal_hit ? cal_sum - AW'(CAL_THR) : cal_sum;
			end
			reverse_power <= |neg; // see RL10
			if (slow_hit && slow_len_q == '0) begin // see RL13
				slow_len_q     <= `ETP_PULSE_LEN_CYC;
				phase_q        <= ~phase_q;
				energy_pulse_a <= ~phase_q;
				energy_pulse_b <= phase_q;
			end else if (slow_len_q != '0) begin
				slow_len_q <= slow_len_q - 1'b1;
				if (slow_len_q == 8'h01) begin
					energy_pulse_a <= 1'b0;
					energy_pulse_b <= 1'b0;
				end
			end
			if (cal_hit && cal_len_q == '0) begin
				cal_len_q       <= `ETP_PULSE_LEN_CYC;
				calib_pulse_out <= 1'b1;
			end else if (cal_len_q != '0) begin
				cal_len_q <= cal_len_q - 1'b1;
				if (cal_len_q == 8'h01) calib_pulse_out <= 1'b0;
			end
		end
	end

	// Checks
	a_gate_low: assert property (@(posedge sys_clk) disable iff (srst) // see RL1
		!sup_good |=> !energy_pulse_a && !energy_pulse_b && !calib_pulse_out)
		else $error("pulse while supply not good");
	a_sup_filter: assert property (@(posedge sys_clk) disable iff (srst) // see RL2
		(sup_q == etp_pkg::ETP_SUP_LOW) ##1 (sup_q == etp_pkg::ETP_SUP_RISE)
		|-> ##1 (sup_q != etp_pkg::ETP_SUP_GOOD))
		else $error("supply accepted without filtering");
	a_rev_any: assert property (@(posedge sys_clk) disable iff (srst || !sup_good) // see RL10
		|neg |=> reverse_power || !sup_good)
		else $error("reverse flag missed");
	a_abs_pos: assert property (@(posedge sys_clk) disable iff (srst) // see RL9
		!sum_mode_select |-> !total[PW+1])
		else $error("magnitude sum negative");
	a_pulse_len: assert property (@(posedge sys_clk) disable iff (srst || !sup_good) // see RL13
		$rose(energy_pulse_a) |-> energy_pulse_a [*8] ##1 !energy_pulse_a)
		else $error("slow pulse length wrong");
	a_ab_excl: assert property (@(posedge sys_clk) disable iff (srst) // see RL14
		!(energy_pulse_a && energy_pulse_b))
		else $error("both slow outputs high");
	a_cal_len: assert property (@(posedge sys_clk) disable iff (srst || !sup_good) // see RL7
		$rose(calib_pulse_out) |-> calib_pulse_out [*8])
		else $error("calib pulse too short");
	a_slow_pulse: assert property (@(posedge sys_clk) disable iff (srst || !sup_good) // see RL6
		(slow_hit && slow_len_q == '0) |=> (energy_pulse_a || energy_pulse_b))
		else $error("threshold crossing gave no pulse");

	// Reset and supply filter
	a_rst_out: assert property (@(posedge sys_clk) // see RL14
		srst |=> !energy_pulse_a && !energy_pulse_b && !calib_pulse_out && !reverse_power)
		else $error("outputs not cleared by reset");
	a_rst_sup: assert property (@(posedge sys_clk) // see RL2
		srst |=> sup_q == etp_pkg::ETP_SUP_LOW)
		else $error("supply state not low after reset");
	a_rst_phase: assert property (@(posedge sys_clk) // see RL13
		srst |=> !phase_q && slow_len_q == '0 && cal_len_q == '0)
		else $error("pulse state not cleared by reset");
	a_low_stay: assert property (@(posedge sys_clk) disable iff (srst) // see RL1
		(sup_q == etp_pkg::ETP_SUP_LOW && !supply_ok) |=> sup_q == etp_pkg::ETP_SUP_LOW)
		else $error("supply left low without supply");
	a_low_cnt: assert property (@(posedge sys_clk) disable iff (srst) // see RL2
		(sup_q == etp_pkg::ETP_SUP_LOW) |=> sup_cnt_q == '0)
		else $error("filter count not cleared");
	a_rise_drop: assert property (@(posedge sys_clk) disable iff (srst) // see RL2
		(sup_q == etp_pkg::ETP_SUP_RISE && !supply_ok) |=> sup_q == etp_pkg::ETP_SUP_LOW)
		else $error("short supply pulse not rejected");
	a_rise_done: assert property (@(posedge sys_clk) disable iff (srst) // see RL2
		(sup_q == etp_pkg::ETP_SUP_RISE && supply_ok && sup_done)
		|=> sup_q == etp_pkg::ETP_SUP_GOOD)
		else $error("filtered supply not accepted");
	a_rise_wait: assert property (@(posedge sys_clk) disable iff (srst) // see RL2
		(sup_q == etp_pkg::ETP_SUP_RISE && !sup_done) |=> sup_q != etp_pkg::ETP_SUP_GOOD)
		else $error("supply accepted early");
	a_good_stay: assert property (@(posedge sys_clk) disable iff (srst) // see RL2
		(sup_q == etp_pkg::ETP_SUP_GOOD && supply_ok) |=> sup_q == etp_pkg::ETP_SUP_GOOD)
		else $error("good supply dropped");
	a_fall_back: assert property (@(posedge sys_clk) disable iff (srst) // see RL2
		(sup_q == etp_pkg::ETP_SUP_FALL && supply_ok) |=> sup_q == etp_pkg::ETP_SUP_GOOD)
		else $error("short dip not rejected");
	a_fall_done: assert property (@(posedge sys_clk) disable iff (srst) // see RL1
		(sup_q == etp_pkg::ETP_SUP_FALL && !supply_ok && sup_done)
		|=> sup_q == etp_pkg::ETP_SUP_LOW)
		else $error("lasting dip not taken");
	a_fall_wait: assert property (@(posedge sys_clk) disable iff (srst) // see RL2
		(sup_q == etp_pkg::ETP_SUP_FALL && !sup_done) |=> sup_q != etp_pkg::ETP_SUP_LOW)
		else $error("supply dropped early");
	a_cnt_max: assert property (@(posedge sys_clk) disable iff (srst) // see RL2
		(sup_q == etp_pkg::ETP_SUP_RISE || sup_q == etp_pkg::ETP_SUP_FALL)
		|-> sup_cnt_q <= `ETP_SUPPLY_FILT_CYC)
		else $error("filter count overran");

	// Sum and sign
	a_rev_off: assert property (@(posedge sys_clk) disable iff (srst) // see RL1
		!sup_good |=> !reverse_power)
		else $error("reverse flag while supply not good");
	a_rev_clear: assert property (@(posedge sys_clk) disable iff (srst || !sup_good) // see RL10
		!(|neg) |=> !reverse_power)
		else $error("reverse flag without negative phase");
	a_sum_neg: assert property (@(posedge sys_clk) disable iff (srst) // see RL8
		(sum_mode_select && (&neg)) |-> total[PW+1])
		else $error("signed sum lost its sign");
	a_abs_ge: assert property (@(posedge sys_clk) disable iff (srst) // see RL9
		!sum_mode_select |-> total >= sum_signed)
		else $error("magnitude sum below signed sum");

	// Accumulators and pulses
	a_hit_idle: assert property (@(posedge sys_clk) disable iff (srst) // see RL6
		!sample_valid |-> !slow_hit && !cal_hit)
		else $error("crossing without a sample");
	a_slow_hold: assert property (@(posedge sys_clk) disable iff (srst || !sup_good) // see RL6
		!sample_valid |=> $stable(slow_acc_q) && $stable(cal_acc_q))
		else $error("accumulator moved without a sample");
	a_slow_sub: assert property (@(posedge sys_clk) disable iff (srst || !sup_good) // see RL6
		slow_hit |=> slow_acc_q == $past(slow_sum) - AW'(SLOW_THR))
		else $error("slow threshold not removed");
	a_cal_sub: assert property (@(posedge sys_clk) disable iff (srst || !sup_good) // see RL7
		cal_hit |=> cal_acc_q == $past(cal_sum) - AW'(CAL_THR))
		else $error("calib threshold not removed");
	a_cal_pulse: assert property (@(posedge sys_clk) disable iff (srst || !sup_good) // see RL7
		(cal_hit && cal_len_q == '0) |=> calib_pulse_out)
		else $error("calib crossing gave no pulse");
	a_alt_a: assert property (@(posedge sys_clk) disable iff (srst || !sup_good) // see RL13
		$rose(energy_pulse_a) |-> phase_q)
		else $error("slow pulse a out of turn");
	a_alt_b: assert property (@(posedge sys_clk) disable iff (srst || !sup_good) // see RL13
		$rose(energy_pulse_b) |-> !phase_q)
		else $error("slow pulse b out of turn");
	a_b_len: assert property (@(posedge sys_clk) disable iff (srst || !sup_good) // see RL13
		$rose(energy_pulse_b) |-> energy_pulse_b [*8] ##1 !energy_pulse_b)
		else $error("slow pulse b length wrong");
	a_cal_end: assert property (@(posedge sys_clk) disable iff (srst || !sup_good) // see RL7
		$rose(calib_pulse_out) |-> calib_pulse_out [*8] ##1 !calib_pulse_out)
		else $error("calib pulse length wrong");
	a_len_max: assert property (@(posedge sys_clk) disable iff (srst) // see RL13
		slow_len_q <= `ETP_PULSE_LEN_CYC && cal_len_q <= `ETP_PULSE_LEN_CYC)
		else $error("pulse length counter overran");
	a_slow_busy: assert property (@(posedge sys_clk) disable iff (srst) // see RL13
		(slow_len_q != '0) |-> energy_pulse_a || energy_pulse_b)
		else $error("slow pulse low while counting");
	a_cal_busy: assert property (@(posedge sys_clk) disable iff (srst) // see RL7
		(cal_len_q != '0) |-> calib_pulse_out)
		else $error("calib pulse low while counting");
endmodule : etp_top

// ===== sim/energy_to_pulse_converter_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module energy_to_pulse_converter_test;
	logic        sys_clk = 1'b0;
	logic        srst = 1'b1;
	logic        supply_ok = 1'b0;
	logic        mode = 1'b1;
	logic        ph = 1'b0;
	logic        sv = 1'b1;
	logic [15:0] amp = 16'h2000;
	logic [15:0] vv;
	logic [15:0] cur [3];
	logic        pa, pb, pc, rev;
	int          sg [3] = '{0, 0, 0};
	int          num_errors = 0;
	int          n_compared = 0;
	int          n_a, n_b, n_cal, n_bad, c0, s0;
	initial forever #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) #2 ph = ~ph;
	assign vv = ph ? amp : 16'h0000 - amp;
	for (genvar k = 0; k < 3; k++) begin : g_cur
		assign cur[k] = sg[k] > 0 ? vv : sg[k] < 0 ? 16'h0000 - vv : 16'h0000;
	end
	etp_top #(.SLOW_THR(32'h4000_0000)) uut (.sys_clk(sys_clk), .srst(srst),
		.sample_valid(sv), .volt_a(vv), .volt_b(vv), .volt_c(vv),
		.curr_a(cur[0]), .curr_b(cur[1]), .curr_c(cur[2]), .supply_ok(supply_ok),
		.sum_mode_select(mode), .energy_pulse_a(pa), .energy_pulse_b(pb),
		.calib_pulse_out(pc), .reverse_power(rev));
	etp_counter far (.sys_clk(sys_clk), .energy_pulse_a(pa), .energy_pulse_b(pb),
		.calib_pulse_out(pc), .gate(supply_ok), .n_a(n_a), .n_b(n_b), .n_cal(n_cal),
		.n_bad(n_bad));
	task automatic run(input int a, input int b, input int c, input logic m,
			input logic sup);
		int  tot;
		logic neg;
		sg = '{a, b, c};
		mode = m;
		supply_ok = sup;
		repeat (8000) @(posedge sys_clk);
		c0 = n_cal;
		s0 = n_a + n_b;
		repeat (6000) @(posedge sys_clk);
		#2;
		tot = m ? a + b + c : (a < 0 ? -a : a) + (b < 0 ? -b : b) + (c < 0 ? -c : c);
		neg = a < 0 || b < 0 || c < 0;
		if (!sup) tot = 0;
		`CHK(rev, neg && sup)
		`CHK(n_cal - c0 > 1, tot != 0)
		`CHK(n_a + n_b - s0 > 1, tot != 0)
		`CHK(n_cal - c0 >= n_a + n_b - s0, 1'b1)
		`CHK(n_bad, 0)
	endtask : run
	task automatic summarize();
		$display("errors=%0d compared=%0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : summarize
	initial begin
		void'($urandom(64));
		repeat (12) @(posedge sys_clk);
		#2 srst = 1'b0;
		amp = 16'h0800 + 16'($urandom % 16'h0800);
		sg = '{1, 1, 1};
		// Supply chatter shorter than the filter must never enable output
		repeat (40) begin
			supply_ok = 1'b1;
			sv = 1'($urandom % 2);
			repeat (200) @(posedge sys_clk);
			#2 supply_ok = 1'b0;
			@(posedge sys_clk);
			#2;
		end
		sv = 1'b1;
		`CHK(n_cal + n_a + n_b, 0)
		run(1, 1, 1, 1'b1, 1'b1);
		run(1, -1, 0, 1'b0, 1'b1);
		run(-1, -1, -1, 1'b0, 1'b1);
		run(1, 1, 1, 1'b1, 1'b0);
		run(1, -1, 0, 1'b1, 1'b1);
		summarize();
	end
endmodule : energy_to_pulse_converter_test

// ===== sim/etp_counter.sv
`timescale 1ns/1ps
// Far-side pulse counter: counts rises, checks width and a/b alternation
module etp_counter (
	input  wire logic sys_clk,
	input  wire logic energy_pulse_a,
	input  wire logic energy_pulse_b,
	input  wire logic calib_pulse_out,
	input  wire logic gate,
	output int        n_a,
	output int        n_b,
	output int        n_cal,
	output int        n_bad
);
	logic [2:0] p;
	logic [2:0] prev = 3'h0;
	int         len [3] = '{0, 0, 0};
	logic       last_b = 1'b1;
	logic       gate_q = 1'b0;
	initial {n_a, n_b, n_cal, n_bad} = '0;
	assign p = {calib_pulse_out, energy_pulse_b, energy_pulse_a};
	// Pulses are sampled as they come; counts are compared as totals
	always @(posedge sys_clk) begin
		for (int k = 0; k < 3; k++) begin
			if (prev[k] === 1'b1 && p[k] === 1'b0 && len[k] != 8 && gate === 1'b1) n_bad++;
			len[k] = (p[k] === 1'b1) ? len[k] + 1 : 0;
		end
		if (gate === 1'b1 && gate_q !== 1'b1) last_b = 1'b1;
		gate_q = gate;
		if (p[0] === 1'b1 && prev[0] === 1'b0) begin
			if (!last_b) n_bad++;
			last_b = 1'b0;
			n_a++;
		end
		if (p[1] === 1'b1 && prev[1] === 1'b0) begin
			if (last_b) n_bad++;
			last_b = 1'b1;
			n_b++;
		end
		if (p[2] === 1'b1 && prev[2] === 1'b0) n_cal++;
		prev = p;
	end
endmodule : etp_counter
